/* File: design/isr_pkg.sv */
// package: offsets, fields, reset values and codes of the interrupt status block
package isr_pkg;

   // ***************************************************
   // register map (byte addresses on the lite bus)
   // ***************************************************
   localparam int          ADDR_W        = 12;                // decoded address bits
   localparam logic [11:0] OFS_STATUS    = 12'h000;           // interrupt_queue_status
   localparam logic [11:0] OFS_IRQ_STS   = 12'h004;           // sticky event bits, write one to clear
   localparam logic [11:0] OFS_IRQ_MSK   = 12'h008;           // event enables

   // ***************************************************
   // status word fields
   // ***************************************************
   localparam int          SVC_LSB       = 16;                // service_index low bit
   localparam int          SVC_MSB       = 30;                // service_index high bit
   localparam int          FULL_BIT      = 15;                // queue_full_flag
   localparam int          CNT_LSB       = 0;                 // pushed_descriptor_count low bit
   localparam int          CNT_MSB       = 14;                // pushed_descriptor_count high bit
   localparam int          CNT_W         = 15;                // count and index width
   localparam logic [14:0] IDX_RST       = 15'h0000;          // index after reset
   localparam logic [14:0] CNT_RST       = 15'h0000;          // count after reset
   localparam logic [14:0] CNT_MAX       = 15'h7fff;          // count saturates here

   // ***************************************************
   // event register bits
   // ***************************************************
   localparam int          IRQ_W         = 2;                 // number of event bits
   localparam int          IRQ_CNT_BIT   = 0;                 // count made nonzero
   localparam int          IRQ_FULL_BIT  = 1;                 // shared queue went full
   localparam logic [1:0]  IRQ_STS_RST   = 2'h0;              // no pending events
   localparam logic [1:0]  IRQ_MSK_RST   = 2'h1;              // count event enabled

   // ***************************************************
   // transfer and descriptor widths
   // ***************************************************
   localparam int          XCNT_W        = 8;                 // descriptors per batch
   localparam int          ERR_W         = 4;                 // receive error code
   localparam int          CODE_W        = 4;                 // descriptor event code
   localparam int          DESC_W        = 8;                 // {error, code}
   localparam logic [3:0]  EV_RX_BOTH    = 4'h1;              // rx buffer end with message end
   localparam logic [3:0]  EV_RX_BUF     = 4'h2;              // rx buffer end alone
   localparam logic [3:0]  EV_RX_MSG     = 4'h3;              // rx message end alone
   localparam logic [3:0]  EV_TX_BUF     = 4'h4;              // tx buffer end
   localparam logic [3:0]  EV_TX_MSG     = 4'h5;              // tx message end
   localparam logic [3:0]  ERR_NONE      = 4'h0;              // no receive error

   // ***************************************************
   // bus answers
   // ***************************************************
   localparam logic [1:0]  RESP_OKAY     = 2'h0;              // normal answer
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;              // unmapped address

endpackage : isr_pkg

/* File: design/isr_event_map.sv */
// module: maps rx/tx buffer and message end events onto interrupt descriptors
module isr_event_map
   import isr_pkg::*;
(
   input  wire logic              clk,            // system clock
   input  wire logic              srst,           // synchronous reset
   input  wire logic              rx_buf_end,     // rx buffer_end_event
   input  wire logic              rx_msg_end,     // rx message_end_event
   input  wire logic [ERR_W-1:0]  rx_err,         // rx error code, zero if none
   input  wire logic              tx_buf_end,     // tx buffer_end_event
   input  wire logic              tx_msg_end,     // tx message_end_event
   output logic                   evt_ready,      // events may be offered
   output logic                   desc_valid,     // descriptor offered
   output logic [DESC_W-1:0]      desc_data,      // {error, code}
   input  wire logic              desc_ready,     // descriptor taken
   output logic                   bsd_err_valid,  // error to buffer status record
   output logic [ERR_W-1:0]       bsd_err_code    // that error
);

   logic [2:0]        pend;       // pending slots: rx, tx buffer, tx message
   logic [DESC_W-1:0] rx_desc;    // captured rx descriptor
   logic              take;       // events taken this cycle
   logic              rx_any;     // any rx event

   assign evt_ready  = ~|pend;
   assign take       = evt_ready & (rx_buf_end | rx_msg_end | tx_buf_end | tx_msg_end);
   assign rx_any     = rx_buf_end | rx_msg_end;
   assign desc_valid = |pend;

   // head of the pending slots, rx first
   always_comb begin
      if (pend[0]) begin
         desc_data = rx_desc;
      end else if (pend[1]) begin
         desc_data = {ERR_NONE, EV_TX_BUF};
      end else begin
         desc_data = {ERR_NONE, EV_TX_MSG};
      end
   end

   // slot load and pop
   always_ff @(posedge clk) begin
      if (srst) begin
         pend <= 3'h0;
      end else if (take) begin
         pend <= {tx_msg_end, tx_buf_end, rx_any};
      end else if (desc_ready & desc_valid) begin
         if (pend[0]) begin
            pend[0] <= 1'b0;
         end else if (pend[1]) begin
            pend[1] <= 1'b0;
         end else begin
            pend[2] <= 1'b0;
         end
      end
   end

   // rx descriptor: both ends folded into one
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_desc <= {ERR_NONE, EV_RX_BOTH};
      end else if (take & rx_any) begin
         if (rx_buf_end & rx_msg_end) begin
            rx_desc <= {rx_err, EV_RX_BOTH};
         end else if (rx_buf_end) begin
            rx_desc <= {rx_err, EV_RX_BUF};
         end else begin
            rx_desc <= {rx_err, EV_RX_MSG};
         end
      end
   end

   // error copy to the buffer status record, no order versus the descriptor
   always_ff @(posedge clk) begin
      if (srst) begin
         bsd_err_valid <= 1'b0;
         bsd_err_code  <= ERR_NONE;
      end else begin
         bsd_err_valid <= take & rx_any & (rx_err != ERR_NONE);
         bsd_err_code  <= rx_err;
      end
   end

endmodule // isr_event_map

/* File: design/isr_top.sv */
// module: interrupt status word, event interrupt and lite bus slave
// Operation
// - rx buffer and message end give one descriptor
// - tx buffer and message end give two
// - rx errors copied to buffer status record
// - no order between status record and descriptor
// - status word lives in device registers
// - status word refreshed after each batch
// - word reset by resets and queue changes
// - bits 30:16 hold host service index
// - service index written only by host
// - bit 15 shows shared queue full
// - bits 14:0 count descriptors pushed
// - writes to count field ignored
// - nonzero count raises interrupt line
// - full queue stops transfers until host update
module isr_top
   import isr_pkg::*;
(
   input  wire logic              SYS_CLK,        // system clock, 100 MHz
   input  wire logic              SRST,           // synchronous reset, active high
   input  wire logic              SOFT_RESET,     // soft chip reset pulse
   input  wire logic              QDESC_WRITE,    // queue pointer or length changed
   input  wire logic              RX_BUF_END,     // rx buffer_end_event
   input  wire logic              RX_MSG_END,     // rx message_end_event
   input  wire logic [ERR_W-1:0]  RX_ERR,         // rx error code
   input  wire logic              TX_BUF_END,     // tx buffer_end_event
   input  wire logic              TX_MSG_END,     // tx message_end_event
   output logic                   EVT_READY,      // events accepted
   output logic                   DESC_VALID,     // descriptor to the mover
   output logic [DESC_W-1:0]      DESC_DATA,      // descriptor {error, code}
   input  wire logic              DESC_READY,     // mover takes descriptor
   output logic                   BSD_ERR_VALID,  // error for buffer status record
   output logic [ERR_W-1:0]       BSD_ERR_CODE,   // that error
   input  wire logic              XFER_DONE,      // batch written to shared queue
   input  wire logic [XCNT_W-1:0] XFER_COUNT,     // descriptors in that batch
   input  wire logic              XFER_FULL,      // shared queue full at batch end
   output logic                   XFER_HOLD,      // mover must stop
   output logic                   IRQ,            // interrupt line, active high
   input  wire logic [31:0]       AWADDR,         // write address
   input  wire logic [2:0]        AWPROT,         // write protection, unused
   input  wire logic              AWVALID,        // write address valid
   output logic                   AWREADY,        // write address ready
   input  wire logic [31:0]       WDATA,          // write data
   input  wire logic [3:0]        WSTRB,          // write byte strobes
   input  wire logic              WVALID,         // write data valid
   output logic                   WREADY,         // write data ready
   output logic [1:0]             BRESP,          // write response
   output logic                   BVALID,         // write response valid
   input  wire logic              BREADY,         // write response ready
   input  wire logic [31:0]       ARADDR,         // read address
   input  wire logic [2:0]        ARPROT,         // read protection, unused
   input  wire logic              ARVALID,        // read address valid
   output logic                   ARREADY,        // read address ready
   output logic [31:0]            RDATA,          // read data
   output logic [1:0]             RRESP,          // read response
   output logic                   RVALID,         // read data valid
   input  wire logic              RREADY          // read data ready
);

   // ***************************************************
   // declarations
   // ***************************************************
   logic [CNT_W-1:0]  service_index;              // host service point
   logic              queue_full_flag;            // shared queue full
   logic [CNT_W-1:0]  pushed_descriptor_count;    // pushed since last read
   logic              hold;                       // transfers stopped
   logic [IRQ_W-1:0]  irq_sts;                    // sticky events
   logic [IRQ_W-1:0]  irq_msk;                    // event enables
   logic [IRQ_W-1:0]  irq_set;                    // events this cycle
   logic              word_clr;                   // status word reset
   logic              map_valid;                  // descriptor from mapper
   logic              map_ready;                  // mover take, gated
   logic              aw_held;                    // write address latched
   logic              w_held;                     // write data latched
   logic [ADDR_W-1:0] aw_addr;                    // latched write address
   logic [31:0]       w_data;                     // latched write data
   logic [3:0]        w_strb;                     // latched strobes
   logic              wr_go;                      // write performed
   logic              rd_go;                      // read performed
   logic [ADDR_W-1:0] rd_addr;                    // read address
   logic              rd_status;                  // status word read
   logic              wr_status;                  // status word written
   logic [31:0]       status_word;                // assembled status word
   logic [31:0]       next_rdata;                 // read mux
   logic              next_rerr;                  // read unmapped
   logic [CNT_W-1:0]  batch;                      // batch size, widened
   logic [CNT_W:0]    sum;                        // count plus batch

   // ***************************************************
   // descriptor mapping
   // ***************************************************

   // event to descriptor mapper
   isr_event_map u_map (
      .clk           (SYS_CLK),
      .srst          (SRST),
      .rx_buf_end    (RX_BUF_END),
      .rx_msg_end    (RX_MSG_END),
      .rx_err        (RX_ERR),
      .tx_buf_end    (TX_BUF_END),
      .tx_msg_end    (TX_MSG_END),
      .evt_ready     (EVT_READY),
      .desc_valid    (map_valid),
      .desc_data     (DESC_DATA),
      .desc_ready    (map_ready),
      .bsd_err_valid (BSD_ERR_VALID),
      .bsd_err_code  (BSD_ERR_CODE)
   );

   // while stopped, no descriptor leaves
   assign DESC_VALID = map_valid & ~hold;
   assign map_ready  = DESC_READY & ~hold;
   assign XFER_HOLD  = hold;

   // ***************************************************
   // bus decode
   // ***************************************************

   // readies: take each write channel once while its own latch is empty and no write answer is pending; read while no read answer is pending
   assign AWREADY = ~aw_held & ~BVALID;
   assign WREADY  = ~w_held & ~BVALID;
   assign ARREADY = ~RVALID;

   // write runs when address and data are both in
   assign wr_go     = aw_held & w_held & ~BVALID;
   assign rd_go     = ARVALID & ARREADY;
   assign rd_addr   = ARADDR[ADDR_W-1:0];
   assign rd_status = rd_go & (rd_addr == OFS_STATUS) & (ARADDR[31:ADDR_W] == '0);
   assign wr_status = wr_go & (aw_addr == OFS_STATUS);

   // status word; host reads it from registers, not memory
   assign status_word = {1'b0, service_index, queue_full_flag, pushed_descriptor_count};

   // write address latch
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (AWVALID & AWREADY) begin
         aw_held <= 1'b1;
         aw_addr <= (AWADDR[31:ADDR_W] == '0) ? AWADDR[ADDR_W-1:0] : 12'hfff;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   // write data latch
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (WVALID & WREADY) begin
         w_held <= 1'b1;
         w_data <= WDATA;
         w_strb <= WSTRB;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   // write response
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         BVALID <= 1'b0;
         BRESP  <= RESP_OKAY;
      end else if (wr_go) begin
         BVALID <= 1'b1;
         if (aw_addr == OFS_STATUS || aw_addr == OFS_IRQ_STS || aw_addr == OFS_IRQ_MSK) begin
            BRESP <= RESP_OKAY;
         end else begin
            BRESP <= RESP_SLVERR;                 // unmapped
         end
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr  = 1'b0;
      if (ARADDR[31:ADDR_W] != '0) begin
         next_rerr = 1'b1;                        // outside the block
      end else begin
         unique case (rd_addr)
            OFS_STATUS:  next_rdata = status_word;
            OFS_IRQ_STS: next_rdata = {30'h0, irq_sts};
            OFS_IRQ_MSK: next_rdata = {30'h0, irq_msk};
            default:     next_rerr  = 1'b1;       // unmapped
         endcase
      end
   end

   // read answer, captured at the address handshake
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0000_0000;
         RRESP  <= RESP_OKAY;
      end else if (rd_go) begin
         RVALID <= 1'b1;
         RDATA  <= next_rdata;
         RRESP  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // ***************************************************
   // status word
   // ***************************************************

   // any reset source clears the whole word
   assign word_clr = SRST | SOFT_RESET | QDESC_WRITE;

   // batch size and saturating sum
   assign batch = {{(CNT_W-XCNT_W){1'b0}}, XFER_COUNT};
   assign sum   = {1'b0, pushed_descriptor_count} + {1'b0, batch};

   // service index: host writes only, device never moves it
   always_ff @(posedge SYS_CLK) begin
      if (word_clr) begin
         service_index <= IDX_RST;
      end else if (wr_status & w_strb[2] & w_strb[3]) begin
         service_index <= w_data[SVC_MSB:SVC_LSB];
      end
   end

   // descriptor count: refreshed per batch, restarts on read, writes ignored
   always_ff @(posedge SYS_CLK) begin
      if (word_clr) begin
         pushed_descriptor_count <= CNT_RST;
      end else if (XFER_DONE) begin
         if (rd_status) begin
            pushed_descriptor_count <= batch;      // set wins
         end else if (sum[CNT_W]) begin
            pushed_descriptor_count <= CNT_MAX;    // saturate
         end else begin
            pushed_descriptor_count <= sum[CNT_W-1:0];
         end
      end else if (rd_status) begin
         pushed_descriptor_count <= CNT_RST;
      end
      // status writes never touch the count
   end

   // full flag: set at batch end, cleared by a read, set wins
   always_ff @(posedge SYS_CLK) begin
      if (word_clr) begin
         queue_full_flag <= 1'b0;
      end else if (XFER_DONE & XFER_FULL) begin
         queue_full_flag <= 1'b1;
      end else if (rd_status) begin
         queue_full_flag <= 1'b0;
      end
   end

   // transfer stop: from full until the host moves its index
   always_ff @(posedge SYS_CLK) begin
      if (word_clr) begin
         hold <= 1'b0;
      end else if (XFER_DONE & XFER_FULL) begin
         hold <= 1'b1;
      end else if (wr_status & w_strb[2] & w_strb[3]) begin
         hold <= 1'b0;
      end
   end

   // ***************************************************
   // interrupt events
   // ***************************************************

   // count made nonzero, queue went full
   always_comb begin
      irq_set               = '0;
      irq_set[IRQ_CNT_BIT]  = XFER_DONE & (XFER_COUNT != '0);
      irq_set[IRQ_FULL_BIT] = XFER_DONE & XFER_FULL;
   end

   // sticky status, write one clears, set wins
   always_ff @(posedge SYS_CLK) begin
      if (SRST | SOFT_RESET) begin
         irq_sts <= IRQ_STS_RST;
      end else if (wr_go & (aw_addr == OFS_IRQ_STS) & w_strb[0]) begin
         irq_sts <= (irq_sts & ~w_data[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_sts <= irq_sts | irq_set;
      end
   end

   // mask register
   always_ff @(posedge SYS_CLK) begin
      if (SRST | SOFT_RESET) begin
         irq_msk <= IRQ_MSK_RST;
      end else if (wr_go & (aw_addr == OFS_IRQ_MSK) & w_strb[0]) begin
         irq_msk <= w_data[IRQ_W-1:0];
      end
   end

   // level interrupt line
   assign IRQ = |(irq_sts & irq_msk);

endmodule // isr_top

/* File: verification/isr_mover.sv */
// partner: descriptor mover that writes batches into the shared queue
module isr_mover
   import isr_pkg::*;
(
   input  wire logic              clk,        // system clock
   input  wire logic              srst,       // reset
   input  wire logic              desc_valid, // descriptor offered
   input  wire logic              xfer_hold,  // block says stop
   input  wire logic              slow,       // stall every other cycle
   input  wire logic              flush,      // write a batch now
   input  wire logic              full_in,    // queue fills with this batch
   output logic                   desc_ready, // descriptor taken
   output logic                   xfer_done,  // batch written
   output logic [XCNT_W-1:0]      xfer_count, // batch size
   output logic                   xfer_full   // queue now full
);
   logic [XCNT_W-1:0] taken; // descriptors since last batch
   initial {desc_ready, xfer_done, xfer_count, xfer_full, taken} = '0;
   // takes descriptors, reports batches, writes nothing while held
   always @(posedge clk) begin
      desc_ready <= slow ? !desc_ready : 1'b1;
      xfer_done <= 1'b0;
      xfer_full <= 1'b0;
      xfer_count <= ~xfer_count; // stale size does not stand
      if (srst) taken <= '0;
      else if (flush && !xfer_hold) begin
         xfer_done <= 1'b1;
         xfer_count <= taken;
         xfer_full <= full_in;
         taken <= '0;
      end else if (desc_valid && desc_ready) taken <= taken + 1'b1;
   end
endmodule // isr_mover

/* File: verification/isr_props.sv */
// checker: timing relations at the status block ports
module isr_props
   import isr_pkg::*;
(
   input wire logic SYS_CLK, SRST, SOFT_RESET, QDESC_WRITE, RX_BUF_END, RX_MSG_END, TX_BUF_END, TX_MSG_END,
   input wire logic [ERR_W-1:0]  RX_ERR, BSD_ERR_CODE,
   input wire logic EVT_READY, DESC_VALID, BSD_ERR_VALID, XFER_DONE, XFER_FULL, XFER_HOLD, IRQ,
   input wire logic [DESC_W-1:0] DESC_DATA,
   input wire logic AWVALID, AWREADY, WVALID, WREADY, BVALID, ARVALID, ARREADY, RVALID
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   logic rx_ev; // rx event taken
   logic tx_ev; // both tx ends taken alone
   assign rx_ev = EVT_READY && (RX_BUF_END || RX_MSG_END);
   assign tx_ev = EVT_READY && TX_BUF_END && TX_MSG_END && !RX_BUF_END && !RX_MSG_END;
   rx_joined_a:
      assert property (rx_ev && RX_BUF_END && RX_MSG_END && !TX_BUF_END && !TX_MSG_END
         |=> DESC_DATA[3:0] == EV_RX_BOTH) else $error("rx ends not joined");
   tx_split_a:
      assert property (tx_ev |=> !EVT_READY && DESC_DATA[3:0] == EV_TX_BUF) else $error("tx ends not split");
   err_copy_a:
      assert property (rx_ev && RX_ERR != ERR_NONE |=> BSD_ERR_VALID && BSD_ERR_CODE == $past(RX_ERR))
         else $error("rx error not copied");
   hold_set_a:
      assert property (XFER_DONE && XFER_FULL && !QDESC_WRITE && !SOFT_RESET |=> XFER_HOLD)
         else $error("full batch did not hold");
   hold_stop_a:
      assert property (XFER_HOLD |-> !DESC_VALID) else $error("descriptor offered while held");
   hold_release_a:
      assert property ($fell(XFER_HOLD) |-> $rose(BVALID) || $past(QDESC_WRITE) || $past(SOFT_RESET))
         else $error("hold dropped without cause");
   soft_irq_a:
      assert property (SOFT_RESET && !XFER_DONE |=> !IRQ) else $error("irq after soft reset");
   write_resp_a:
      assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID) else $error("late write answer");
   read_resp_a:
      assert property (ARVALID && ARREADY |=> RVALID) else $error("late read answer");
endmodule // isr_props
bind isr_top isr_props u_props (.*);

/* File: verification/tb_interrupt_status_reporting.sv */
// testbench: status word, event mapping, batches and event registers
module tb_interrupt_status_reporting
   import isr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic SYS_CLK = 0, SRST = 1, SOFT_RESET = 0, QDESC_WRITE = 0, RX_BUF_END = 0, RX_MSG_END = 0;
   logic TX_BUF_END = 0, TX_MSG_END = 0, AWVALID = 0, WVALID = 0, ARVALID = 0, slow = 0, flush = 0, full_in = 0;
   logic [ERR_W-1:0] RX_ERR = '0;
   logic [31:0] AWADDR = '0, WDATA = '0, ARADDR = '0;
   logic [3:0] WSTRB = '0;
   logic EVT_READY, DESC_VALID, DESC_READY, BSD_ERR_VALID, XFER_DONE, XFER_FULL, XFER_HOLD, IRQ;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [DESC_W-1:0] DESC_DATA;
   logic [ERR_W-1:0] BSD_ERR_CODE;
   logic [XCNT_W-1:0] XFER_COUNT;
   logic [1:0] BRESP, RRESP;
   logic [31:0] RDATA;
   int err_total = 0, num_checks = 0, cycles = 0, seed = 50, n = 0;
   logic [33:0] exp_rd[$], msk_rd[$]; // read notes and care masks
   logic [DESC_W-1:0] exp_desc[$];    // descriptor notes
   logic [ERR_W-1:0] exp_bsd[$];      // status record notes
   always #5 SYS_CLK = ~SYS_CLK;
   isr_top u_dut (.*, .AWPROT(3'h0), .ARPROT(3'h0), .BREADY(1'b1), .RREADY(1'b1));
   isr_mover u_mover (.clk(SYS_CLK), .srst(SRST), .desc_valid(DESC_VALID), .xfer_hold(XFER_HOLD), .slow,
      .flush, .full_in, .desc_ready(DESC_READY), .xfer_done(XFER_DONE), .xfer_count(XFER_COUNT),
      .xfer_full(XFER_FULL));
   task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // lite write: both channels offered, each released when taken
   task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
      logic aw = 1, w = 1;
      AWADDR <= {20'h0, a};
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      while (aw || w) begin
         @(posedge SYS_CLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         aw = aw && !AWREADY;
         w = w && !WREADY;
      end
      do @(posedge SYS_CLK); while (!BVALID);
      chk("bresp", BRESP, RESP_OKAY);
   endtask
   // lite read: note what is expected, the monitor compares
   task automatic rd(logic [11:0] a, logic [33:0] e, logic [33:0] m = '1);
      ARADDR <= {20'h0, a};
      ARVALID <= 1'b1;
      exp_rd.push_back(e & m);
      msk_rd.push_back(m);
      do @(posedge SYS_CLK); while (!ARREADY);
      ARVALID <= 1'b0;
      do @(posedge SYS_CLK); while (!RVALID);
   endtask
   // one event kind: 0 rx both, 1 rx buffer, 2 rx message, 3 tx both
   task automatic ev(int k);
      logic [ERR_W-1:0] e;
      e = (k < 3) ? ERR_W'($random(seed)) : ERR_NONE;
      do @(posedge SYS_CLK); while (!EVT_READY);
      {RX_BUF_END, RX_MSG_END, TX_BUF_END, TX_MSG_END} <= {k < 2, k == 0 || k == 2, k == 3, k == 3};
      RX_ERR <= e;
      if (k < 3) exp_desc.push_back({e, k == 0 ? EV_RX_BOTH : k == 1 ? EV_RX_BUF : EV_RX_MSG});
      else exp_desc.push_back({ERR_NONE, EV_TX_BUF});
      if (k == 3) exp_desc.push_back({ERR_NONE, EV_TX_MSG});
      if (e != ERR_NONE) exp_bsd.push_back(e);
      n += (k == 3) ? 2 : 1;
      @(posedge SYS_CLK);
      {RX_BUF_END, RX_MSG_END, TX_BUF_END, TX_MSG_END} <= 4'h0;
   endtask
   // wait until drained, then let the mover write one batch
   task automatic batch(logic f);
      do @(posedge SYS_CLK); while (!EVT_READY || DESC_VALID);
      full_in <= f;
      flush <= 1'b1;
      @(posedge SYS_CLK);
      flush <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
   endtask
   // monitor: oldest note against each result, plus the run ceiling
   always @(posedge SYS_CLK) begin
      if (RVALID) chk("read", {RRESP, RDATA} & msk_rd.pop_front(), exp_rd.pop_front());
      if (DESC_VALID && DESC_READY) chk("descriptor", DESC_DATA, exp_desc.pop_front());
      if (BSD_ERR_VALID) chk("status record", BSD_ERR_CODE, exp_bsd.pop_front());
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge SYS_CLK);
      SRST <= 1'b0;
      rd(OFS_STATUS, 0);
      rd(OFS_IRQ_MSK, 34'(IRQ_MSK_RST));
      rd(OFS_IRQ_STS, 34'(IRQ_STS_RST));
      $display("test reset done");
      slow <= 1'b1;
      for (int i = 0; i < 12; i++) ev(i % 4);
      batch(1'b0);
      chk("irq", IRQ, 1);
      rd(OFS_STATUS, n);
      rd(OFS_STATUS, 0);
      wr(OFS_STATUS, 32'hffffffff, 4'hf);
      rd(OFS_STATUS, 32'h7fff0000);
      $display("test count and index done");
      ev(3);
      batch(1'b1);
      chk("hold", XFER_HOLD, 1);
      ev(1);
      repeat (4) @(posedge SYS_CLK);
      chk("held", DESC_VALID, 0);
      rd(OFS_STATUS, 32'h7fff8002);
      rd(OFS_STATUS, 32'h7fff0000);
      wr(OFS_STATUS, 32'h00030000, 4'hf);
      chk("hold", XFER_HOLD, 0);
      batch(1'b0);
      $display("test full queue done");
      rd(OFS_IRQ_STS, 32'h3);
      wr(OFS_IRQ_STS, 32'h3, 4'hf);
      chk("irq clear", IRQ, 0);
      wr(OFS_IRQ_MSK, 32'h0, 4'hf);
      ev(2);
      batch(1'b0);
      chk("irq masked", IRQ, 0);
      rd(OFS_IRQ_STS, 32'h1);
      @(posedge SYS_CLK);
      QDESC_WRITE <= 1'b1;
      @(posedge SYS_CLK);
      QDESC_WRITE <= 1'b0;
      rd(OFS_STATUS, 0);
      wr(OFS_STATUS, 32'h00050000, 4'hf);
      SOFT_RESET <= 1'b1;
      @(posedge SYS_CLK);
      SOFT_RESET <= 1'b0;
      rd(OFS_STATUS, 0);
      rd(OFS_IRQ_MSK, 34'(IRQ_MSK_RST));
      rd(12'h010, {RESP_SLVERR, 32'h0}, {2'h3, 32'h0});
      $display("test resets and bus done");
      wrap_up();
   end
endmodule // tb_interrupt_status_reporting
